// ---- common/cpl_defs.vh ----
// constants for the core clock ratio and l2 clock divider block
// assumes inclusion by rtl and sim files; holds definitions, no logic
`ifndef CPL_DEFS_VH
`define CPL_DEFS_VH

// ***************************************************************
// register map (byte addresses, one aligned word each)
// ***************************************************************
`define CPL_ADDR_L2_CTRL    8'h00
`define CPL_ADDR_STATUS     8'h04
`define CPL_L2_CTRL_RESET   5'h00

// l2 control register fields
`define CPL_DIV_LSB         0
`define CPL_DIV_MSB         2
`define CPL_LOWFREQ_BIT     3
`define CPL_DLL_EN_BIT      4

// divisor field codes, l2 period in core periods
`define CPL_DIV_OFF         3'h0
`define CPL_DIV_1_0         3'h1
`define CPL_DIV_1_5         3'h2
`define CPL_DIV_2_0         3'h3
`define CPL_DIV_2_5         3'h4
`define CPL_DIV_3_0         3'h5

// ***************************************************************
// ratio strap codes and multipliers (in halves)
// ***************************************************************
`define CPL_CFG_X2_0        4'h4
`define CPL_CFG_X3_0        4'h8
`define CPL_CFG_X3_5        4'he
`define CPL_CFG_X4_0        4'ha
`define CPL_CFG_X4_5        4'h7
`define CPL_CFG_X5_0        4'hb
`define CPL_CFG_X5_5        4'h9
`define CPL_CFG_X6_0        4'hd
`define CPL_CFG_X6_5        4'h5
`define CPL_CFG_X7_0        4'h2
`define CPL_CFG_X7_5        4'h1
`define CPL_CFG_X8_0        4'hc
`define CPL_CFG_X10_0       4'h6
`define CPL_CFG_BYPASS      4'h3
`define CPL_CFG_OFF         4'hf

`define CPL_MULT_BYPASS     5'h02
`define CPL_MULT_NONE       5'h00
`define CPL_VCO_PER_CORE    2'h2

// ***************************************************************
// status register fields
// ***************************************************************
`define CPL_ST_STRAP_LSB    0
`define CPL_ST_MULT_LSB     4
`define CPL_ST_BYPASS_BIT   9
`define CPL_ST_OFF_BIT      10
`define CPL_ST_RSVD_BIT     11
`define CPL_ST_LOCK_BIT     12
`define CPL_ST_TAP_LSB      13

`endif

// ---- rtl/cpl_l2_dll.v ----
// delay-locked phase aligner for the divided l2 clock
// assumes fb_in is synchronous to clock and returns the delayed clock
`timescale 1ns/1ps
`default_nettype none

module cpl_l2_dll #(
    parameter TAPS   = 16,
    parameter TAP_W  = 4
) (
    input  wire             clock,
    input  wire             sys_rst,
    input  wire             enable,
    input  wire             ref_in,
    input  wire             fb_in,
    output reg              clk_out,
    output wire             locked,
    output wire [TAP_W-1:0] tap
);

    reg  [TAPS-1:0]  line_reg;
    reg  [TAP_W-1:0] tap_reg;
    reg              ref_d_reg;
    reg              dir_reg;
    reg              locked_reg;
    reg              primed_reg;
    wire             ref_rise;

    assign ref_rise = ref_in & ~ref_d_reg;
    assign locked   = locked_reg;
    assign tap      = tap_reg;

    // ***********************************************************
    // delay line and phase detector
    // ***********************************************************
    always @(posedge clock) begin
        if (sys_rst) begin
            line_reg   <= {TAPS{1'b0}};
            tap_reg    <= {TAP_W{1'b0}};
            ref_d_reg  <= 1'b0;
            dir_reg    <= 1'b0;
            locked_reg <= 1'b0;
            primed_reg <= 1'b0;
            clk_out    <= 1'b0;
        end else begin
            line_reg  <= {line_reg[TAPS-2:0], ref_in};
            ref_d_reg <= ref_in;
            clk_out   <= line_reg[tap_reg];
            if (!enable) begin
                tap_reg    <= {TAP_W{1'b0}};
                locked_reg <= 1'b0;
                primed_reg <= 1'b0;
            end else if (ref_rise) begin
                // feedback already high means it came early: add delay
                if (fb_in && tap_reg != TAPS - 1) begin
                    tap_reg <= tap_reg + 1'b1;
                end else if (!fb_in && tap_reg != {TAP_W{1'b0}}) begin
                    tap_reg <= tap_reg - 1'b1;
                end
                dir_reg    <= fb_in;
                primed_reg <= 1'b1;
                // a reversal of direction marks the edge straddled; the
                // first sample has no direction yet, so it cannot lock
                if (primed_reg && dir_reg != fb_in) begin
                    locked_reg <= 1'b1;
                end
            end
        end
    end

endmodule // cpl_l2_dll

`default_nettype wire

// ---- rtl/cpl_clock_ctrl.v ----
// core clock ratio decode and l2 sram clock divider, ahb-lite slave
// assumes clock is the vco-rate clock, one hclk domain, straps steady
//
// Function
// - core clock is bus clock times strap ratio
// - codes for ratios 2 through 5.5
// - codes for ratios 6 through 10
// - code 0011 clocks core from bus clock
// - bypass disables pll, forces 1:1 bus
// - code 1111 stops all internal clocking
// - l2 clock divided from core, dll aligned; in bypass it is still divided from clock, not from the bus-rate core
// - divisor field gives 1, 1.5, 2, 2.5, 3
// - feedback clock out, returned to dll
//
// The address map and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "cpl_defs.vh"

module cpl_clock_ctrl #(
    parameter DLL_TAPS  = 16,
    parameter DLL_TAP_W = 4
) (
    input  wire        clock,
    input  wire        sys_rst,
    // board straps and bus clock
    input  wire [3:0]  ratio_strap,
    input  wire        bus_clock_input,
    // clock outputs
    output reg         core_clock_out,
    output reg         pll_enable,
    output reg         bus_ratio_one_to_one,
    output reg  [4:0]  core_mult_halves,
    output wire        l2_clock_out,
    output wire        l2_feedback_clock_out,
    input  wire        l2_feedback_clock_in,
    output reg         l2_low_frequency_select,
    // ahb-lite slave
    input  wire        hsel,
    input  wire [7:0]  haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output wire        hreadyout,
    output wire        hresp,
    output reg  [31:0] hrdata
);

    reg  [3:0]  strap_reg;
    reg         strap_taken_reg;
    reg  [4:0]  mult_next;
    reg         bypass_next;
    reg         off_next;
    reg         rsvd_next;
    reg         rsvd_reg;
    reg         vco_half_reg;
    reg  [4:0]  l2_ctrl_reg;
    reg  [2:0]  l2_cnt_reg;
    reg         l2_ref_reg;
    reg  [2:0]  l2_period;
    reg         wr_pend_reg;
    reg  [7:0]  wr_addr_reg;
    wire        addr_phase;
    wire        dll_locked;
    wire        l2_clk_dly;
    wire [DLL_TAP_W-1:0] dll_tap;
    wire [31:0] status_word;
    wire [2:0]  div_field;

    assign div_field = l2_ctrl_reg[`CPL_DIV_MSB:`CPL_DIV_LSB];

    // ***************************************************************
    // strap capture
    // ***************************************************************
    // strap taken once, first edge after reset release; later changes
    // are ignored so a glitching strap cannot upset running clocks
    // strap sampled once
    always @(posedge clock) begin
        if (sys_rst) begin
            strap_reg       <= `CPL_CFG_OFF;
            strap_taken_reg <= 1'b0;
        end else if (!strap_taken_reg) begin
            strap_reg       <= ratio_strap;
            strap_taken_reg <= 1'b1;
        end
    end

    // ***************************************************************
    // ratio decode
    // ***************************************************************
    always @* begin
        mult_next   = `CPL_MULT_NONE;
        bypass_next = 1'b0;
        off_next    = 1'b0;
        rsvd_next   = 1'b0;
        case (strap_reg)
            `CPL_CFG_X2_0:   mult_next = 5'h04;
            `CPL_CFG_X3_0:   mult_next = 5'h06;
            `CPL_CFG_X3_5:   mult_next = 5'h07;
            `CPL_CFG_X4_0:   mult_next = 5'h08;
            `CPL_CFG_X4_5:   mult_next = 5'h09;
            `CPL_CFG_X5_0:   mult_next = 5'h0a;
            `CPL_CFG_X5_5:   mult_next = 5'h0b;
            `CPL_CFG_X6_0:   mult_next = 5'h0c;
            `CPL_CFG_X6_5:   mult_next = 5'h0d;
            `CPL_CFG_X7_0:   mult_next = 5'h0e;
            `CPL_CFG_X7_5:   mult_next = 5'h0f;
            `CPL_CFG_X8_0:   mult_next = 5'h10;
            `CPL_CFG_X10_0:  mult_next = 5'h14;
            `CPL_CFG_BYPASS: begin
                mult_next   = `CPL_MULT_BYPASS;
                bypass_next = 1'b1;
            end
            `CPL_CFG_OFF:    off_next = 1'b1;
            // reserved codes are treated as off, the safest choice
            default: begin
                off_next  = 1'b1;
                rsvd_next = 1'b1;
            end
        endcase
    end

    // ***************************************************************
    // core clock generation
    // ***************************************************************
    // clock stands for the vco; core runs at half of it
    always @(posedge clock) begin
        if (sys_rst || !strap_taken_reg) begin
            vco_half_reg         <= 1'b0;
            core_clock_out       <= 1'b0;
            pll_enable           <= 1'b0;
            bus_ratio_one_to_one <= 1'b0;
            core_mult_halves     <= `CPL_MULT_NONE;
            rsvd_reg             <= 1'b0;
        end else begin
            rsvd_reg             <= rsvd_next;
            core_mult_halves     <= mult_next;
            pll_enable           <= ~bypass_next & ~off_next;
            bus_ratio_one_to_one <= bypass_next;
            vco_half_reg         <= ~vco_half_reg;
            if (off_next) begin
                core_clock_out <= 1'b0;
            end else if (bypass_next) begin
                core_clock_out <= bus_clock_input;
            end else begin
                core_clock_out <= vco_half_reg;
            end
        end
    end

    // ***************************************************************
    // l2 clock divider
    // ***************************************************************
    // l2 period in vco cycles is twice the divisor: 2,3,4,5,6
    always @* begin
        case (div_field)
            `CPL_DIV_1_0: l2_period = 3'h2;
            `CPL_DIV_1_5: l2_period = 3'h3;
            `CPL_DIV_2_0: l2_period = 3'h4;
            `CPL_DIV_2_5: l2_period = 3'h5;
            `CPL_DIV_3_0: l2_period = 3'h6;
            default:      l2_period = 3'h0;
        endcase
    end

    always @(posedge clock) begin
        if (sys_rst || pll_enable == 1'b0 && !bus_ratio_one_to_one ||
                l2_period == 3'h0) begin
            l2_cnt_reg <= 3'h0;
            l2_ref_reg <= 1'b0;
        end else begin
            if (l2_cnt_reg >= l2_period - 3'h1) begin
                l2_cnt_reg <= 3'h0;
            end else begin
                l2_cnt_reg <= l2_cnt_reg + 3'h1;
            end
            // low for the rounded-up half period; odd periods (divisors 1.5, 2.5) skew
            l2_ref_reg <= (l2_cnt_reg < ((l2_period + 3'h1) >> 1)) ?
                          1'b0 : 1'b1;
        end
    end

    cpl_l2_dll #(
        .TAPS    (DLL_TAPS),
        .TAP_W   (DLL_TAP_W)
    ) u_dll (
        .clock   (clock),
        .sys_rst (sys_rst),
        .enable  (l2_ctrl_reg[`CPL_DLL_EN_BIT]),
        .ref_in  (l2_ref_reg),
        .fb_in   (l2_feedback_clock_in),
        .clk_out (l2_clk_dly),
        .locked  (dll_locked),
        .tap     (dll_tap)
    );

    assign l2_clock_out          = l2_clk_dly;
    assign l2_feedback_clock_out = l2_clk_dly;

    // ***************************************************************
    // ahb-lite register slave
    // ***************************************************************
    // zero wait states, always okay; unmapped reads give zero
    assign hreadyout  = 1'b1;
    assign hresp      = 1'b0;
    assign addr_phase = hsel & hready & htrans[1];

    assign status_word = {{(32 - `CPL_ST_TAP_LSB - DLL_TAP_W){1'b0}},
                          dll_tap, dll_locked, rsvd_reg, off_next &
                          strap_taken_reg, bus_ratio_one_to_one,
                          core_mult_halves, strap_reg};

    always @(posedge clock) begin
        if (sys_rst) begin
            wr_pend_reg             <= 1'b0;
            wr_addr_reg             <= 8'h00;
            hrdata                  <= 32'h0000_0000;
            l2_ctrl_reg             <= `CPL_L2_CTRL_RESET;
            l2_low_frequency_select <= 1'b0;
        end else begin
            wr_pend_reg <= addr_phase & hwrite;
            wr_addr_reg <= haddr;
            if (addr_phase && !hwrite) begin
                case (haddr)
                    `CPL_ADDR_L2_CTRL: hrdata <= {27'h0, l2_ctrl_reg};
                    `CPL_ADDR_STATUS:  hrdata <= status_word;
                    default:           hrdata <= 32'h0000_0000;
                endcase
            end
            if (wr_pend_reg && wr_addr_reg == `CPL_ADDR_L2_CTRL) begin
                l2_ctrl_reg             <= hwdata[4:0];
                l2_low_frequency_select <= hwdata[`CPL_LOWFREQ_BIT];
            end
        end
    end

endmodule // cpl_clock_ctrl

`default_nettype wire

// ---- sim/cpl_far_model.sv ----
// far side: free-running bus clock and board feedback trace
// assumes one clock; trace delay is a whole number of cycles
`timescale 1ns/1ps
`default_nettype none
module cpl_far_model #(
    parameter BUS_HALF = 3,
    parameter FB_DLY   = 2
) (
    input  wire logic clock,
    output wire logic bus_clock_input,
    input  wire logic l2_feedback_clock_out,
    output wire logic l2_feedback_clock_in
);
    logic [FB_DLY-1:0] trace_reg = '0;
    logic              bclk_reg = 1'b0;
    integer            cnt = 0;
    assign bus_clock_input = bclk_reg;
    always @(posedge clock) begin
        cnt <= (cnt == BUS_HALF - 1) ? 0 : cnt + 1;
        if (cnt == BUS_HALF - 1) bclk_reg <= !bclk_reg;
    end
    always @(posedge clock) begin
        trace_reg <= {trace_reg[FB_DLY-2:0], l2_feedback_clock_out};
    end
    assign l2_feedback_clock_in = trace_reg[FB_DLY-1];
endmodule // cpl_far_model
`default_nettype wire

// ---- sim/cpl_props.sv ----
// port checker for the clock control block
// assumes bind onto cpl_clock_ctrl, a single clock domain
`timescale 1ns/1ps
`default_nettype none
`include "cpl_defs.vh"
module cpl_props #(
    parameter DLL_TAPS  = 16,
    parameter DLL_TAP_W = 4
) (
    input wire logic        clock,
    input wire logic        sys_rst,
    input wire logic        bus_clock_input,
    input wire logic        core_clock_out,
    input wire logic        pll_enable,
    input wire logic        bus_ratio_one_to_one,
    input wire logic [4:0]  core_mult_halves,
    input wire logic        l2_clock_out,
    input wire logic        l2_feedback_clock_out,
    input wire logic        l2_low_frequency_select,
    input wire logic        hsel,
    input wire logic [7:0]  haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    wire logic tk = hsel && hready && htrans[1];
    // *****************
    // assertions
    // *****************
    a_core_toggle: assert property (
        pll_enable && $past(pll_enable)
        |-> core_clock_out != $past(core_clock_out))
        else $error("core clock stalled in multiply mode");
    a_mult_legal: assert property (
        pll_enable && $past(pll_enable)
        |-> core_mult_halves inside {5'h04, [5'h06:5'h10], 5'h14})
        else $error("illegal multiplier in multiply mode");
    a_bypass_follow: assert property (
        bus_ratio_one_to_one && $past(bus_ratio_one_to_one)
        |-> core_clock_out == $past(bus_clock_input))
        else $error("core clock not following bus clock");
    a_bypass_ratio: assert property (
        bus_ratio_one_to_one |-> !pll_enable && core_mult_halves == 5'h02)
        else $error("bypass without pll off and one to one");
    a_off_quiet: assert property (
        !pll_enable && !bus_ratio_one_to_one
        && $past(!pll_enable && !bus_ratio_one_to_one) |-> !core_clock_out)
        else $error("core clock running while stopped");
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("slave stalled or errored");
    a_lowfreq_write: assert property (
        tk && hwrite && haddr == `CPL_ADDR_L2_CTRL ##1 1 |=>
        l2_low_frequency_select == $past(hwdata[`CPL_LOWFREQ_BIT]))
        else $error("low frequency select not written");
    a_fb_copy: assert property (
        l2_feedback_clock_out == l2_clock_out)
        else $error("feedback clock differs from l2 clock");
    c_bypass: cover property (bus_ratio_one_to_one);
    c_write: cover property (tk && hwrite);
    c_l2_rise: cover property ($rose(l2_clock_out));
endmodule // cpl_props
bind cpl_clock_ctrl cpl_props #(.DLL_TAPS(DLL_TAPS), .DLL_TAP_W(DLL_TAP_W))
    u_cpl_props (.clock, .sys_rst, .bus_clock_input, .core_clock_out,
    .pll_enable, .bus_ratio_one_to_one, .core_mult_halves, .l2_clock_out,
    .l2_feedback_clock_out, .l2_low_frequency_select, .hsel, .haddr,
    .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp);
`default_nettype wire

// ---- sim/cpl_clock_ctrl_tb.sv ----
// bench for the clock control block: straps, registers, l2 divider
// assumes the far model closes the feedback loop, hready from hreadyout
`timescale 1ns/1ps
`default_nettype none
`include "cpl_defs.vh"
module cpl_clock_ctrl_tb;
    logic clock, sys_rst, hsel, hwrite, bclk, fbi;
    logic [3:0] ratio_strap;
    logic [7:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, d;
    wire logic cco, pll, one, l2o, fbo, lfs, hreadyout, hresp;
    wire logic [4:0] mlt;
    wire logic [31:0] hrdata;
    integer fails = 0, total_checks = 0, i, n;
    logic [3:0] cfg [0:14] = '{4'h4, 4'h8, 4'he, 4'ha, 4'h7, 4'hb, 4'h9,
        4'hd, 4'h5, 4'h2, 4'h1, 4'hc, 4'h6, 4'h3, 4'hf};
    logic [4:0] mh [0:14] = '{5'h04, 5'h06, 5'h07, 5'h08, 5'h09, 5'h0a,
        5'h0b, 5'h0c, 5'h0d, 5'h0e, 5'h0f, 5'h10, 5'h14, 5'h02, 5'h00};
    always #2.5 clock = !clock;
    cpl_clock_ctrl u_cpl_clock_ctrl (.clock(clock), .sys_rst(sys_rst),
        .ratio_strap(ratio_strap), .bus_clock_input(bclk),
        .core_clock_out(cco), .pll_enable(pll), .bus_ratio_one_to_one(one),
        .core_mult_halves(mlt), .l2_clock_out(l2o),
        .l2_feedback_clock_out(fbo), .l2_feedback_clock_in(fbi),
        .l2_low_frequency_select(lfs), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata));
    cpl_far_model u_cpl_far_model (.clock(clock), .bus_clock_input(bclk),
        .l2_feedback_clock_out(fbo), .l2_feedback_clock_in(fbi));
    // *****************
    // tasks
    // *****************
    task end_sim;
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task chk(input [31:0] s, input [31:0] e);
        total_checks++;
        if (s !== e) begin
            fails++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    // bounded wait on hready; a hang ends the run
    task rdy;
        integer k;
        k = 0;
        @(posedge clock);
        while (hreadyout !== 1'b1) begin
            if (++k > 50) begin
                fails++;
                end_sim;
            end
            @(posedge clock);
        end
    endtask
    task xfer(input [7:0] a, input w, input [31:0] wd);
        @(posedge clock);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'b10;
        hsize <= 3'h2;
        rdy;
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        rdy;
        d = hrdata;
    endtask
    // strap only moves under reset, so each code needs its own reset
    task boot(input [3:0] s, input integer c);
        ratio_strap <= s;
        sys_rst <= 1'b1;
        repeat (c) @(posedge clock);
        sys_rst <= 1'b0;
        repeat (3) @(posedge clock);
    endtask
    // *****************
    // sequence
    // *****************
    initial begin
        {clock, hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
        sys_rst = 1'b1;
        ratio_strap = 4'ha;
        boot(4'ha, 12);
        xfer(`CPL_ADDR_L2_CTRL, 0, 0);
        chk(d, 32'h0);
        xfer(8'h08, 0, 0);
        chk(d, 32'h0);
        xfer(`CPL_ADDR_STATUS, 1, 32'hffff_ffff);
        xfer(`CPL_ADDR_STATUS, 0, 0);
        chk(d, 32'h0000_008a);
        // low field kept as 100 MHz core gives l2 below 110 MHz
        // only the listed divisor codes and off are programmed
        for (i = 5; i >= 0; i--) begin
            xfer(`CPL_ADDR_L2_CTRL, 1, 32'h08 | i);
            xfer(`CPL_ADDR_L2_CTRL, 0, 0);
            chk(d, 32'h08 | i);
            chk(lfs, 1'b1);
            repeat (20) @(posedge clock);
            n = 0;
            // sample mid-cycle, away from the edge that moves l2o
            @(negedge clock);
            d[0] = l2o;
            repeat (60) begin
                @(negedge clock);
                if (l2o === 1'b1 && d[0] !== 1'b1) n++;
                d[0] = l2o;
            end
            chk(n, i == 0 ? 0 : 60 / (i + 1));
        end
        xfer(`CPL_ADDR_L2_CTRL, 1, 32'h1b);
        for (i = 0; i < 100 && d[`CPL_ST_LOCK_BIT] !== 1'b1; i++)
            xfer(`CPL_ADDR_STATUS, 0, 0);
        chk(d[`CPL_ST_LOCK_BIT], 1'b1);
        // only listed codes, against one fixed bus clock rate
        for (i = 0; i < 15; i++) begin
            boot(cfg[i], 2);
            xfer(`CPL_ADDR_STATUS, 0, 0);
            chk(d, {21'h0, i == 14, i == 13, mh[i], cfg[i]});
            chk(mlt, mh[i]);
            chk(pll, i < 13);
            chk(one, i == 13);
        end
        end_sim;
    end
endmodule // cpl_clock_ctrl_tb
`default_nettype wire
